//--- include/incjmp_cfg.svh
`ifndef INCJMP_CFG_SVH
`define INCJMP_CFG_SVH

// Register byte offsets
`define IJ_OFS_INSTR    8'h00
`define IJ_OFS_WREG     8'h04
`define IJ_OFS_BANKSEL  8'h08
`define IJ_OFS_STATUS   8'h0C
`define IJ_OFS_PC       8'h10
`define IJ_OFS_MADDR    8'h14
`define IJ_OFS_MDATA    8'h18
`define IJ_OFS_STATE    8'h1C

// Instruction encodings
`define IJ_INC_OPC      6'h0A
`define IJ_JMP1_OPC     8'hEF
`define IJ_JMP2_OPC     4'hF

// Flag bit positions in the status register
`define IJ_FLAG_C       0
`define IJ_FLAG_DIG     1
`define IJ_FLAG_Z       2
`define IJ_FLAG_OVF     3
`define IJ_FLAG_N       4

// Increment word: destination and bank-access select bits
`define IJ_DEST_BIT     9
`define IJ_BANK_BIT     8

// Access bank: low half of bank 0 and high half of the top bank
`define IJ_ACC_SPLIT    8'h80
`define IJ_ACC_LO_BANK  4'h0
`define IJ_ACC_HI_BANK  4'hF

// Reset values and steps
`define IJ_RST_WREG     8'h00
`define IJ_RST_BANKSEL  4'h0
`define IJ_RST_MADDR    12'h000
`define IJ_RST_STATUS   5'h00
`define IJ_RST_PC       21'h000000
`define IJ_PC_STEP      21'h000002
`define IJ_INC_ONE      9'h001
`define IJ_NIB_ONE      5'h01
`define IJ_OVF_EDGE     8'h7F

`endif

//--- include/incjmp_pkg.sv
package incjmp_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_MRD,
    ST_JNOP
  } exec_state_e;

  typedef struct packed {
    exec_state_e st;
    logic [7:0]  wreg;
    logic [3:0]  bank_select_register;
    logic [4:0]  status;
    logic [20:0] pc;
    logic [11:0] mem_addr;
    logic [11:0] op_addr;
    logic        op_to_file;
    logic [7:0]  jmp_lo;
    logic        jmp_pend;
  } exec_regs_s;

endpackage : incjmp_pkg

//--- rtl/file_reg_mem.sv
`timescale 1ns/1ns
module file_reg_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input  wire logic          core_clk_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [DW-1:0] wdata_in,
  output logic      [DW-1:0] rdata_out
);

  logic [DW-1:0] mem_q [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;

  // No reset: contents are software-defined, read data lags one cycle
  always_ff @(posedge core_clk_in)
  begin
    if (we_in)
    begin
      mem_q[addr_in] <= wdata_in;
    end
    rdata_q <= mem_q[addr_in];
  end

  assign rdata_out = rdata_q;

endmodule : file_reg_mem

//--- rtl/increment_and_jump_exec.sv
// How it works
// - Increment reads the addressed file register, adds one, yields the sum.
// - Destination bit 0 sends the sum to the working register only.
// - Destination bit 1 writes the sum back into the register read.
// - Bank bit 0 uses the access bank, ignoring the bank select register.
// - Bank bit 1 takes the bank from the bank select register.
// - Absolute jump takes two cycles; the second is a no-operation.
// - Jump target bits 7:0 from word one, 19:8 from word two, into PC 20:1.
// - Jump reaches all of the 2 Mbyte program space regardless of page.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "incjmp_cfg.svh"
module increment_and_jump_exec #(
  parameter int MEM_AW = 12
) (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out
);

  incjmp_pkg::exec_regs_s s_q;
  incjmp_pkg::exec_regs_s s_d;

  logic              mem_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [7:0]        mem_wd;
  logic [7:0]        mem_rd;

  logic              acc;
  logic [15:0]       iw;
  logic [7:0]        f_ofs;
  logic [11:0]       ea;
  logic [8:0]        sum9;
  logic [4:0]        nib5;
  logic [7:0]        res;

  file_reg_mem #(
    .AW (MEM_AW),
    .DW (8)
  ) u_mem (
    .core_clk_in (core_clk_in),
    .we_in       (mem_we),
    .addr_in     (mem_addr),
    .wdata_in    (mem_wd),
    .rdata_out   (mem_rd)
  );

  always_comb
  begin
    s_d         = s_q;
    acc         = psel_in & penable_in;
    iw          = pwdata_in[15:0];
    f_ofs       = iw[7:0];
    mem_we      = 1'b0;
    mem_addr    = s_q.op_addr[MEM_AW-1:0];
    mem_wd      = 8'h00;
    pready_out  = 1'b0;
    pslverr_out = 1'b0;
    prdata_out  = 32'h00000000;
    sum9        = {1'b0, mem_rd} + `IJ_INC_ONE;
    nib5        = {1'b0, mem_rd[3:0]} + `IJ_NIB_ONE;
    res         = sum9[7:0];
    if (iw[`IJ_BANK_BIT])
    begin
      ea = {s_q.bank_select_register, f_ofs};
    end
    else if (f_ofs < `IJ_ACC_SPLIT)
    begin
      ea = {`IJ_ACC_LO_BANK, f_ofs};
    end
    else
    begin
      ea = {`IJ_ACC_HI_BANK, f_ofs};
    end
    unique case (s_q.st)
      incjmp_pkg::ST_IDLE:
      begin
        if (acc)
        begin
          pready_out = 1'b1;
          unique case (paddr_in)
            `IJ_OFS_INSTR:
            begin
              if (pwrite_in)
              begin
                if (s_q.jmp_pend)
                begin
                  s_d.jmp_pend = 1'b0;
                  if (iw[15:12] == `IJ_JMP2_OPC)
                  begin
                    // Full 20-bit target, no page bits kept
                    s_d.pc     = {iw[11:0], s_q.jmp_lo, 1'b0};
                    s_d.st     = incjmp_pkg::ST_JNOP;
                    pready_out = 1'b0;
                  end
                  else
                  begin
                    // Broken pair: skip both words as no-operations
                    s_d.pc = s_q.pc + `IJ_PC_STEP + `IJ_PC_STEP;
                  end
                end
                else if (iw[15:8] == `IJ_JMP1_OPC)
                begin
                  s_d.jmp_lo   = iw[7:0];
                  s_d.jmp_pend = 1'b1;
                end
                else if (iw[15:10] == `IJ_INC_OPC)
                begin
                  s_d.op_addr    = ea;
                  s_d.op_to_file = iw[`IJ_DEST_BIT];
                  mem_addr       = ea[MEM_AW-1:0];
                  s_d.st         = incjmp_pkg::ST_EXEC;
                  pready_out     = 1'b0;
                end
                else
                begin
                  // Other opcodes are not executed here
                  s_d.pc = s_q.pc + `IJ_PC_STEP;
                end
              end
            end
            `IJ_OFS_WREG:
            begin
              prdata_out = {24'h000000, s_q.wreg};
              if (pwrite_in)
              begin
                s_d.wreg = pwdata_in[7:0];
              end
            end
            `IJ_OFS_BANKSEL:
            begin
              prdata_out = {28'h0000000, s_q.bank_select_register};
              if (pwrite_in)
              begin
                s_d.bank_select_register = pwdata_in[3:0];
              end
            end
            `IJ_OFS_STATUS:
            begin
              prdata_out = {27'h0000000, s_q.status};
              if (pwrite_in)
              begin
                s_d.status = pwdata_in[4:0];
              end
            end
            `IJ_OFS_PC:
            begin
              prdata_out = {11'h000, s_q.pc};
              if (pwrite_in)
              begin
                s_d.pc = {pwdata_in[20:1], 1'b0};
              end
            end
            `IJ_OFS_MADDR:
            begin
              prdata_out = {20'h00000, s_q.mem_addr};
              if (pwrite_in)
              begin
                s_d.mem_addr = pwdata_in[11:0];
              end
            end
            `IJ_OFS_MDATA:
            begin
              mem_addr = s_q.mem_addr[MEM_AW-1:0];
              if (pwrite_in)
              begin
                mem_we = 1'b1;
                mem_wd = pwdata_in[7:0];
              end
              else
              begin
                // Memory read data is registered, so reads take one extra cycle
                s_d.st     = incjmp_pkg::ST_MRD;
                pready_out = 1'b0;
              end
            end
            `IJ_OFS_STATE:
            begin
              prdata_out = {31'h00000000, s_q.jmp_pend};
            end
            default:
            begin
              pslverr_out = 1'b1;
            end
          endcase
        end
      end
      incjmp_pkg::ST_EXEC:
      begin
        pready_out = 1'b1;
        if (s_q.op_to_file)
        begin
          mem_we = 1'b1;
          mem_wd = res;
        end
        else
        begin
          s_d.wreg = res;
        end
        s_d.status[`IJ_FLAG_C]  = sum9[8];
        s_d.status[`IJ_FLAG_DIG] = nib5[4];
        s_d.status[`IJ_FLAG_Z]   = (res == 8'h00);
        s_d.status[`IJ_FLAG_OVF] = (mem_rd == `IJ_OVF_EDGE);
        s_d.status[`IJ_FLAG_N]  = res[7];
        s_d.pc = s_q.pc + `IJ_PC_STEP;
        s_d.st = incjmp_pkg::ST_IDLE;
      end
      incjmp_pkg::ST_MRD:
      begin
        mem_addr   = s_q.mem_addr[MEM_AW-1:0];
        pready_out = 1'b1;
        prdata_out = {24'h000000, mem_rd};
        s_d.st     = incjmp_pkg::ST_IDLE;
      end
      incjmp_pkg::ST_JNOP:
      begin
        // Second jump cycle does nothing while the target is fetched
        pready_out = 1'b1;
        s_d.st     = incjmp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      s_q.st                   <= incjmp_pkg::ST_IDLE;
      s_q.wreg                 <= `IJ_RST_WREG;
      s_q.bank_select_register <= `IJ_RST_BANKSEL;
      s_q.status               <= `IJ_RST_STATUS;
      s_q.pc                   <= `IJ_RST_PC;
      s_q.mem_addr             <= `IJ_RST_MADDR;
      s_q.op_addr              <= `IJ_RST_MADDR;
      s_q.op_to_file           <= 1'b0;
      s_q.jmp_lo               <= 8'h00;
      s_q.jmp_pend             <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule : increment_and_jump_exec

//--- testbench/incjmp_chk.sv
`timescale 1ns/1ns
module incjmp_chk (
  input wire logic        core_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  logic pend_q;
  logic su_w;
  logic rd_ok;
  assign su_w  = psel_in && !penable_in && pwrite_in && paddr_in == 8'h00;
  assign rd_ok = psel_in && penable_in && !pwrite_in && pready_out;
  // Own copy of the jump-pending flag
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
    if (sys_rst_in)
      pend_q <= 1'b0;
    else if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == 8'h00)
      pend_q <= !pend_q && pwdata_in[15:8] == 8'hEF;
  a_inc_one_wait: assert property (su_w && !pend_q && pwdata_in[15:10] == 6'h0A
    |=> !pready_out ##1 pready_out) else $error("increment timing");
  a_jmp_first_fast: assert property (su_w && !pend_q && pwdata_in[15:8] == 8'hEF
    |=> pready_out) else $error("jump first word timing");
  a_jmp_two_cycle: assert property (su_w && pend_q && pwdata_in[15:12] == 4'hF
    |=> !pready_out ##1 pready_out) else $error("jump no-op cycle missing");
  a_mem_read_wait: assert property (psel_in && !penable_in && !pwrite_in
    && paddr_in == 8'h18 |=> !pready_out ##1 pready_out) else $error("memory read timing");
  a_pend_state: assert property (rd_ok && paddr_in == 8'h1C
    |-> prdata_out == {31'h0, pend_q}) else $error("jump pending state");
  a_pc_even: assert property (rd_ok && paddr_in == 8'h10
    |-> prdata_out[31:21] == 11'h0 && !prdata_out[0]) else $error("pc shape");
  a_status_width: assert property (rd_ok && paddr_in == 8'h0C
    |-> prdata_out[31:5] == 27'h0) else $error("status width");
  a_wreg_width: assert property (rd_ok && paddr_in == 8'h04
    |-> prdata_out[31:8] == 24'h0) else $error("wreg width");
endmodule : incjmp_chk

bind increment_and_jump_exec incjmp_chk chk_u (.core_clk_in(core_clk_in),
  .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out));

//--- testbench/tb_increment_and_jump_exec.sv
`timescale 1ns/1ns
module tb_increment_and_jump_exec;
  logic        core_clk_in = 1'b0;
  logic        sys_rst_in  = 1'b1;
  logic        psel_in     = 1'b0;
  logic        penable_in  = 1'b0;
  logic        pwrite_in   = 1'b0;
  logic [7:0]  paddr_in    = 8'h00;
  logic [31:0] pwdata_in   = 32'h0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic [31:0] rd_q;
  logic        err_q;
  int          n_errors    = 0;
  int          n_tests     = 0;
  int          cyc         = 0;

  increment_and_jump_exec #(.MEM_AW(12)) dut_u (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out));

  always #10 core_clk_in = ~core_clk_in;

  task automatic print_verdict();
    $display("Counts: %0d compares, %0d errors", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Ready sampled at the rising edge; request held until then, idle cycle after
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic bad;
    bad        = (a > 8'h1C) || (a[1:0] != 2'b00);
    psel_in    <= 1'b1;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do
    begin
      @(posedge core_clk_in);
    end
    while (pready_out !== 1'b1);
    rd_q  = prdata_out;
    err_q = pslverr_out;
    chk({31'h0, err_q}, {31'h0, bad});
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge core_clk_in);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask : rd

  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      print_verdict();
    end
  end

  initial
  begin
    repeat (12) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    rd(8'h10, 32'h0);
    wr(8'h04, 32'h55);
    wr(8'h08, 32'h2);
    wr(8'h14, 32'h234);
    wr(8'h18, 32'hFF);
    wr(8'h00, 32'h2934);
    rd(8'h04, 32'h00);
    rd(8'h18, 32'hFF);
    rd(8'h0C, 32'h07);
    rd(8'h10, 32'h2);
    $display("test inc_to_w done");
    wr(8'h14, 32'h27F);
    wr(8'h18, 32'h11);
    wr(8'h14, 32'h07F);
    wr(8'h18, 32'h7F);
    wr(8'h00, 32'h2A7F);
    rd(8'h18, 32'h80);
    rd(8'h0C, 32'h1A);
    rd(8'h04, 32'h00);
    wr(8'h14, 32'h27F);
    rd(8'h18, 32'h11);
    wr(8'h14, 32'hF90);
    wr(8'h18, 32'h0F);
    wr(8'h00, 32'h2A90);
    rd(8'h18, 32'h10);
    rd(8'h0C, 32'h02);
    $display("test inc_to_file done");
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h1FFFFE);
    wr(8'h00, 32'hEF56);
    rd(8'h1C, 32'h1);
    wr(8'h00, 32'hFABC);
    rd(8'h10, 32'h1578AC);
    rd(8'h1C, 32'h0);
    $display("test jump done");
    wr(8'h00, 32'hEF00);
    wr(8'h00, 32'h0000);
    rd(8'h10, 32'h1578B0);
    rd(8'h1C, 32'h0);
    wr(8'h00, 32'h0000);
    rd(8'h10, 32'h1578B2);
    $display("test broken_pair done");
    rd(8'h20, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    $display("test unmapped done");
    print_verdict();
  end
endmodule : tb_increment_and_jump_exec
